// ### tps_consts.vh
/*
  constants for the trap priority sequencer: register offsets, field
  positions, reset values and vector numbers.
  assumes inclusion by bare name from tps_trap_priority_sequencer.v.
*/
`ifndef TPS_CONSTS_VH
`define TPS_CONSTS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define TPS_OFS_VEC_BASE   4'h0
`define TPS_OFS_STATUS     4'h4
`define TPS_OFS_FLAG_CLR   4'h8
`define TPS_OFS_LAST_PC    4'hC

// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define TPS_ST_TIMER_BIT   0
`define TPS_ST_TRACE_BIT   1
`define TPS_ST_SENSE0_BIT  2
`define TPS_ST_SENSE2_BIT  3
`define TPS_ST_VEC_LSB     8
`define TPS_ST_VEC_MSB     15
`define TPS_VEC_BASE_RST   32'h00000000
`define TPS_VEC_FIELD_LSB  2
`define TPS_VEC_FIELD_MSB  9

// ------------------------------------------------------------
// vector numbers
// ------------------------------------------------------------
`define TPS_V_ILLEGAL      8'h00
`define TPS_V_UNALIGNED    8'h01
`define TPS_V_OUT_RANGE    8'h02
`define TPS_V_PROTECT      8'h05
`define TPS_V_UNSUP_PERIPH 8'h06
`define TPS_V_USER_IMISS   8'h08
`define TPS_V_USER_DMISS   8'h09
`define TPS_V_SUP_IMISS    8'h0A
`define TPS_V_SUP_DMISS    8'h0B
`define TPS_V_TIMER        8'h0E
`define TPS_V_TRACE        8'h0F
`define TPS_V_EXT0         8'h10
`define TPS_V_EXT2         8'h12
`define TPS_V_PERIPH       8'h13
`define TPS_V_FP_EXC       8'h16
`define TPS_V_EMU_FIRST    8'h35
`define TPS_V_EMU_LAST     8'h3F
`define TPS_V_SW_FIRST     8'h40

`endif

// ### tps_trap_priority_sequencer.v
/*
  trap priority sequencer: resolves pending interrupts and traps by a fixed
  nine-level order, picks the 8-bit vector, the vector table address and the
  resume pc, with a classic wishbone register slave.
  assumes: instruction trap inputs are same-clock pulses from the pipeline,
  external request lines are asynchronous pins.
*/
// Chosen here: the placing of the registers and the Wishbone register port.
// What this block does
// - emulation traps use vectors 53 to 63
// - assert and emulate take instruction-supplied vector
// - withdrawn external request vectors as illegal opcode
// - hardware never raises floating-point exception trap
// - protection violation for user and supervisor ops
// - highest priority first, others stay pending
// - levels eight and nine are never latched
// - timer and trace flags pend until taken/cleared
// - top-level traps taken at once, lost on reset
// - unaligned trap regenerated on channel restart
// - instruction traps save current or next pc
// - async events save first unexecuted address
// - level one: data misses, unsupported peripheral
// - level two traps save next; unaligned captures
// - ext zero, ext two, peripheral, timer, trace
// - levels eight, nine save current, no capture
// - tracing and breakpoints, no status output pins
// - vector number fills bits nine to two
// - every taken event has eight-bit vector
// - unsupported peripheral access raises vector six
`timescale 1ns/1ps
`include "tps_consts.vh"
`default_nettype none

module tps_trap_priority_sequencer (
  input  wire        ref_clk_i,
  input  wire        rst_b_i,
  input  wire        core_reset_i,
  input  wire [31:0] curr_pc_i,
  input  wire [31:0] next_pc_i,
  input  wire        async_take_ok_i,
  input  wire        user_dmiss_i,
  input  wire        sup_dmiss_i,
  input  wire        unsup_periph_i,
  input  wire        unaligned_i,
  input  wire        chan_restart_unaligned_i,
  input  wire        out_of_range_i,
  input  wire        assert_trap_i,
  input  wire        emulate_trap_i,
  input  wire [7:0]  instr_vector_i,
  input  wire        emu_op_trap_i,
  input  wire [3:0]  emu_op_index_i,
  input  wire        ext_irq_line_zero_i,
  input  wire        ext_irq_line_two_i,
  input  wire        periph_irq_i,
  input  wire        timer_set_i,
  input  wire        trace_set_i,
  input  wire        breakpoint_i,
  input  wire        user_imiss_i,
  input  wire        sup_imiss_i,
  input  wire        illegal_op_i,
  input  wire        user_bad_op_i,
  input  wire        sup_virt_op_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         take_o,
  output reg  [7:0]  vector_o,
  output reg  [31:0] vector_addr_o,
  output reg  [31:0] saved_resume_pc_o,
  output reg         capture_channel_o,
  output reg         ext_irq_ack_zero_o,
  output reg         ext_irq_ack_two_o,
  output reg         periph_irq_ack_o
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function [7:0] emu_vector;
    input [3:0] idx;
    reg   [7:0] v;
    begin
      v = `TPS_V_EMU_FIRST + {4'h0, idx};
      if (idx > 4'hA) begin
        v = `TPS_V_EMU_LAST;
      end
      emu_vector = v;
    end
  endfunction

  function [31:0] byte_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    integer      k;
    begin
      byte_merge = old_v;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          byte_merge[k*8 +: 8] = new_v[k*8 +: 8];
        end
      end
    end
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  reg [1:0] ext0_sync_reg;
  reg [1:0] ext2_sync_reg;
  reg [1:0] ext_blank_reg;
  wire      ext0_lvl = ext0_sync_reg[1];
  wire      ext2_lvl = ext2_sync_reg[1];
  wire      ext0_new = ext0_lvl & ~ext_irq_ack_zero_o & ~ext_blank_reg[0];
  wire      ext2_new = ext2_lvl & ~ext_irq_ack_two_o & ~ext_blank_reg[1];

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ext0_sync_reg <= 2'h0;
      ext2_sync_reg <= 2'h0;
      ext_blank_reg <= 2'h0;
    end else begin
      ext_blank_reg <= {ext_irq_ack_two_o, ext_irq_ack_zero_o};
      ext0_sync_reg <= {ext0_sync_reg[0], ext_irq_line_zero_i};
      ext2_sync_reg <= {ext2_sync_reg[0], ext_irq_line_two_i};
    end
  end

  // ------------------------------------------------------------
  // registers and held state
  // ------------------------------------------------------------
  reg  [31:0] vec_base_reg;
  reg         timer_flag_reg;
  reg         timer_flag_next;
  reg         trace_flag_pending_reg;
  reg         trace_flag_next;
  reg         sense0_reg;
  reg         sense0_next;
  reg         sense2_reg;
  reg         sense2_next;

  wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_wr    = wb_req & wb_we_i;
  wire clr_wr   = wb_wr & (wb_adr_i == `TPS_OFS_FLAG_CLR);
  wire clr_tmr  = clr_wr & wb_sel_i[0] & wb_dat_i[`TPS_ST_TIMER_BIT];
  wire clr_trc  = clr_wr & wb_sel_i[0] & wb_dat_i[`TPS_ST_TRACE_BIT];

  // ------------------------------------------------------------
  // priority resolution
  // ------------------------------------------------------------
  reg        sel_take;
  reg [7:0]  sel_vec;
  reg        sel_next;
  reg        sel_capture;
  reg        take_ext0;
  reg        take_ext2;
  reg        take_periph;
  reg        take_timer;
  reg        take_trace;

  always @* begin
    sel_take    = 1'b1;
    sel_vec     = `TPS_V_ILLEGAL;
    sel_next    = 1'b1;
    sel_capture = 1'b0;
    take_ext0   = 1'b0;
    take_ext2   = 1'b0;
    take_periph = 1'b0;
    take_timer  = 1'b0;
    take_trace  = 1'b0;
    // the floating-point exception vector is left to emulation software
    if (user_dmiss_i) begin
      sel_vec     = `TPS_V_USER_DMISS;
      sel_capture = 1'b1;
    end else if (sup_dmiss_i) begin
      sel_vec     = `TPS_V_SUP_DMISS;
      sel_capture = 1'b1;
    end else if (unsup_periph_i) begin
      sel_vec     = `TPS_V_UNSUP_PERIPH;
      sel_capture = 1'b1;
    end else if (unaligned_i | chan_restart_unaligned_i) begin
      sel_vec     = `TPS_V_UNALIGNED;
      sel_capture = 1'b1;
    end else if (out_of_range_i) begin
      sel_vec     = `TPS_V_OUT_RANGE;
    end else if (assert_trap_i | emulate_trap_i) begin
      sel_vec     = instr_vector_i;
    end else if (emu_op_trap_i) begin
      sel_vec     = emu_vector(emu_op_index_i);
    end else if (async_take_ok_i & sense0_reg) begin
      take_ext0   = 1'b1;
      sel_vec     = ext0_lvl ? `TPS_V_EXT0 : `TPS_V_ILLEGAL;
    end else if (async_take_ok_i & sense2_reg) begin
      take_ext2   = 1'b1;
      sel_vec     = ext2_lvl ? `TPS_V_EXT2 : `TPS_V_ILLEGAL;
    end else if (async_take_ok_i & periph_irq_i) begin
      take_periph = 1'b1;
      sel_vec     = `TPS_V_PERIPH;
    end else if (async_take_ok_i & timer_flag_reg) begin
      take_timer  = 1'b1;
      sel_vec     = `TPS_V_TIMER;
    end else if (async_take_ok_i & trace_flag_pending_reg) begin
      take_trace  = 1'b1;
      sel_vec     = `TPS_V_TRACE;
    end else if (user_imiss_i) begin
      sel_vec     = `TPS_V_USER_IMISS;
      sel_next    = 1'b0;
    end else if (sup_imiss_i) begin
      sel_vec     = `TPS_V_SUP_IMISS;
      sel_next    = 1'b0;
    end else if (illegal_op_i) begin
      sel_vec     = `TPS_V_ILLEGAL;
      sel_next    = 1'b0;
    end else if (user_bad_op_i | sup_virt_op_i) begin
      sel_vec     = `TPS_V_PROTECT;
      sel_next    = 1'b0;
    end else begin
      sel_take    = 1'b0;
    end
    // lower instruction traps not chosen are simply not latched and recur
    if (core_reset_i) begin
      sel_take    = 1'b0;
      take_ext0   = 1'b0;
      take_ext2   = 1'b0;
      take_periph = 1'b0;
      take_timer  = 1'b0;
      take_trace  = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // pending flags
  // ------------------------------------------------------------
  always @* begin
    timer_flag_next = timer_flag_reg;
    if (take_timer | clr_tmr) begin
      timer_flag_next = 1'b0;
    end
    if (timer_set_i) begin
      timer_flag_next = 1'b1;
    end
    trace_flag_next = trace_flag_pending_reg;
    if (take_trace | clr_trc) begin
      trace_flag_next = 1'b0;
    end
    if (trace_set_i | breakpoint_i) begin
      trace_flag_next = 1'b1;
    end
    // a sensed request stays sensed until taken or core reset, then re-sampled
    sense0_next = take_ext0 ? 1'b0 : (sense0_reg | ext0_new);
    sense2_next = take_ext2 ? 1'b0 : (sense2_reg | ext2_new);
    if (core_reset_i) begin
      sense0_next = 1'b0;
      sense2_next = 1'b0;
    end
  end

  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_flag_reg         <= 1'b0;
      trace_flag_pending_reg <= 1'b0;
      sense0_reg             <= 1'b0;
      sense2_reg             <= 1'b0;
    end else begin
      timer_flag_reg         <= timer_flag_next;
      trace_flag_pending_reg <= trace_flag_next;
      sense0_reg             <= sense0_next;
      sense2_reg             <= sense2_next;
    end
  end

  // ------------------------------------------------------------
  // taken event outputs
  // ------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      take_o             <= 1'b0;
      vector_o           <= 8'h00;
      vector_addr_o      <= 32'h00000000;
      saved_resume_pc_o  <= 32'h00000000;
      capture_channel_o  <= 1'b0;
      ext_irq_ack_zero_o <= 1'b0;
      ext_irq_ack_two_o  <= 1'b0;
      periph_irq_ack_o   <= 1'b0;
    end else begin
      take_o             <= sel_take;
      capture_channel_o  <= sel_take & sel_capture;
      ext_irq_ack_zero_o <= take_ext0;
      ext_irq_ack_two_o  <= take_ext2;
      periph_irq_ack_o   <= take_periph;
      if (sel_take) begin
        vector_o          <= sel_vec;
        vector_addr_o     <= {vec_base_reg[31:10], sel_vec, 2'h0};
        saved_resume_pc_o <= sel_next ? next_pc_i : curr_pc_i;
      end
    end
  end

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      vec_base_reg <= `TPS_VEC_BASE_RST;
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h00000000;
      if (wb_wr & (wb_adr_i == `TPS_OFS_VEC_BASE)) begin
        vec_base_reg <= byte_merge(vec_base_reg, wb_dat_i, wb_sel_i) & 32'hFFFFFC00;
      end
      if (wb_req & ~wb_we_i) begin
        case (wb_adr_i)
          `TPS_OFS_VEC_BASE: begin
            wb_dat_o <= vec_base_reg;
          end
          `TPS_OFS_STATUS: begin
            wb_dat_o <= {16'h0000, vector_o, 4'h0, sense2_reg, sense0_reg,
                         trace_flag_pending_reg, timer_flag_reg};
          end
          `TPS_OFS_LAST_PC: begin
            wb_dat_o <= saved_resume_pc_o;
          end
          default: begin
            wb_dat_o <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// ### tps_irq_src_model.sv
/*
  model of one interrupt source on the far side of the sequencer.
  assumes the request line is sampled on ref_clk_i and idles low.
*/
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// request source
// ------------------------------------------------------------
module tps_irq_src_model (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic raise_i,
  input  wire logic withdraw_i,
  input  wire logic ack_i,
  output wire logic line_o
);
  logic held_reg = 1'b0;
  // request stays up until acknowledged; withdraw breaks this on purpose
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) held_reg <= 1'b0;
    else if (raise_i) held_reg <= 1'b1;
    else if (ack_i || withdraw_i) held_reg <= 1'b0;
  end
  assign line_o = held_reg & ~ack_i;
endmodule
`default_nettype wire

// ### tps_trap_priority_sequencer_properties.sv
/*
  concurrent checks on the trap priority sequencer ports.
  assumes binding into tps_trap_priority_sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
module tps_seq_properties (
  input wire logic        ref_clk_i,
  input wire logic        rst_b_i,
  input wire logic        core_reset_i,
  input wire logic [31:0] curr_pc_i,
  input wire logic [31:0] next_pc_i,
  input wire logic        async_take_ok_i,
  input wire logic        user_dmiss_i,
  input wire logic        sup_dmiss_i,
  input wire logic        unsup_periph_i,
  input wire logic        unaligned_i,
  input wire logic        chan_restart_unaligned_i,
  input wire logic        out_of_range_i,
  input wire logic        assert_trap_i,
  input wire logic        emulate_trap_i,
  input wire logic [7:0]  instr_vector_i,
  input wire logic        emu_op_trap_i,
  input wire logic [3:0]  emu_op_index_i,
  input wire logic        user_imiss_i,
  input wire logic        sup_imiss_i,
  input wire logic        take_o,
  input wire logic [7:0]  vector_o,
  input wire logic [31:0] vector_addr_o,
  input wire logic [31:0] saved_resume_pc_o,
  input wire logic        capture_channel_o,
  input wire logic        periph_irq_ack_o,
  input wire logic        ext_irq_ack_zero_o,
  input wire logic        ext_irq_ack_two_o
);
  // ------------------------------------------------------------
  // helpers and properties
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  wire logic hi_sw = user_dmiss_i | sup_dmiss_i | unsup_periph_i | unaligned_i
                     | chan_restart_unaligned_i | out_of_range_i;
  wire logic hi_emu = hi_sw | assert_trap_i | emulate_trap_i;
  wire logic any_inst = hi_emu | emu_op_trap_i | user_imiss_i | sup_imiss_i;
  a_data_miss_first: assert property (user_dmiss_i && !core_reset_i |=> take_o && vector_o == 8'h09
    && capture_channel_o && saved_resume_pc_o == $past(next_pc_i)) else $error("data miss take wrong");
  a_reset_drops_trap: assert property (core_reset_i |=> !take_o)
    else $error("take during core reset");
  a_emu_vector_map: assert property (emu_op_trap_i && !hi_emu && !core_reset_i |=> vector_o ==
    ($past(emu_op_index_i) > 4'hA ? 8'h3F : 8'h35 + {4'h0, $past(emu_op_index_i)})) else $error("emulation vector wrong");
  a_instr_vector_used: assert property ((assert_trap_i || emulate_trap_i) && !hi_sw && !core_reset_i |=>
    vector_o == $past(instr_vector_i) && saved_resume_pc_o == $past(next_pc_i)) else $error("instruction vector wrong");
  a_vector_addr_field: assert property (take_o |-> vector_addr_o[9:2] == vector_o
    && vector_addr_o[1:0] == 2'b00) else $error("vector address field wrong");
  a_no_fp_vector: assert property (take_o && !$past(assert_trap_i) && !$past(emulate_trap_i)
    |-> vector_o != 8'h16) else $error("hardware produced fp exception vector");
  a_low_saves_curr: assert property (user_imiss_i && !hi_emu && !emu_op_trap_i && !async_take_ok_i
    && !core_reset_i |=> take_o && vector_o == 8'h08 && saved_resume_pc_o == $past(curr_pc_i)
    && !capture_channel_o) else $error("instruction miss take wrong");
  a_imiss_not_latched: assert property (user_imiss_i && user_dmiss_i && !core_reset_i
    ##1 !any_inst && !async_take_ok_i |=> !take_o) else $error("deferred low trap was latched");
  a_periph_ack_pair: assert property (periph_irq_ack_o |-> take_o && vector_o == 8'h13)
    else $error("peripheral ack without its take");
  a_unaligned_capture: assert property ((unaligned_i || chan_restart_unaligned_i) && !user_dmiss_i
    && !sup_dmiss_i && !unsup_periph_i && !core_reset_i |=> vector_o == 8'h01 && capture_channel_o)
    else $error("unaligned take wrong");
  a_ext0_single_take: assert property (ext_irq_ack_zero_o |=> (!ext_irq_ack_zero_o) [*3])
    else $error("ext line zero taken twice");
  a_ext2_single_take: assert property (ext_irq_ack_two_o |=> (!ext_irq_ack_two_o) [*3])
    else $error("ext line two taken twice");
  c_timer_take: cover property (take_o && vector_o == 8'h0E);
  c_capture: cover property (capture_channel_o);
  c_periph_take: cover property (periph_irq_ack_o);
endmodule
bind tps_trap_priority_sequencer tps_seq_properties u_tps_seq_properties (.ref_clk_i, .rst_b_i,
  .core_reset_i, .curr_pc_i, .next_pc_i, .async_take_ok_i, .user_dmiss_i, .sup_dmiss_i,
  .unsup_periph_i, .unaligned_i, .chan_restart_unaligned_i, .out_of_range_i, .assert_trap_i,
  .emulate_trap_i, .instr_vector_i, .emu_op_trap_i, .emu_op_index_i, .user_imiss_i, .sup_imiss_i,
  .take_o, .vector_o, .vector_addr_o, .saved_resume_pc_o, .capture_channel_o, .periph_irq_ack_o,
  .ext_irq_ack_zero_o, .ext_irq_ack_two_o);
`default_nettype wire

// ### tps_trap_priority_sequencer_bench.sv
/*
  self-checking bench for the trap priority sequencer.
  assumes tps_irq_src_model and the bound checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tps_trap_priority_sequencer_bench;
  // ------------------------------------------------------------
  // stimulus, design and sources
  // ------------------------------------------------------------
  localparam logic [31:0] CPC = 32'h00001000;
  localparam logic [31:0] NPC = 32'h00001004;
  localparam logic [31:0] VB  = 32'hFFFFFC00;
  localparam logic [7:0] VT [0:13] = '{8'h09, 8'h0B, 8'h06, 8'h01, 8'h01, 8'h02, 8'h00,
                                        8'h00, 8'h00, 8'h08, 8'h0A, 8'h00, 8'h05, 8'h05};
  logic clk = 1'b0, rst_b = 1'b0, crst = 1'b0, ok = 1'b0, tmr = 1'b0, trc = 1'b0, bkp = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [13:0] trp = 14'h0000;
  logic [7:0]  ivec = 8'h00;
  logic [3:0]  eidx = 4'h0, adr = 4'h0;
  logic [2:0]  rse = 3'h0, wdr = 3'h0;
  logic [31:0] wd = 32'h00000000, q;
  wire  [2:0]  line, iack;
  wire  [31:0] rd, va, spc;
  wire  [7:0]  vec;
  wire         ack, take, cap;
  int          fails = 0, num_checks = 0;
  tps_trap_priority_sequencer u_tps_trap_priority_sequencer (.ref_clk_i(clk), .rst_b_i(rst_b),
    .core_reset_i(crst), .curr_pc_i(CPC), .next_pc_i(NPC), .async_take_ok_i(ok),
    .user_dmiss_i(trp[0]), .sup_dmiss_i(trp[1]), .unsup_periph_i(trp[2]), .unaligned_i(trp[3]),
    .chan_restart_unaligned_i(trp[4]), .out_of_range_i(trp[5]), .assert_trap_i(trp[6]),
    .emulate_trap_i(trp[7]), .instr_vector_i(ivec), .emu_op_trap_i(trp[8]), .emu_op_index_i(eidx),
    .ext_irq_line_zero_i(line[0]), .ext_irq_line_two_i(line[1]), .periph_irq_i(line[2]),
    .timer_set_i(tmr), .trace_set_i(trc), .breakpoint_i(bkp), .user_imiss_i(trp[9]),
    .sup_imiss_i(trp[10]), .illegal_op_i(trp[11]), .user_bad_op_i(trp[12]), .sup_virt_op_i(trp[13]),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .take_o(take), .vector_o(vec), .vector_addr_o(va),
    .saved_resume_pc_o(spc), .capture_channel_o(cap), .ext_irq_ack_zero_o(iack[0]),
    .ext_irq_ack_two_o(iack[1]), .periph_irq_ack_o(iack[2]));
  for (genvar g = 0; g < 3; g++) begin : g_src
    tps_irq_src_model u_tps_irq_src_model (.clk_i(clk), .rst_b_i(rst_b), .raise_i(rse[g]),
      .withdraw_i(wdr[g]), .ack_i(iack[g]), .line_o(line[g]));
  end
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rd;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    chk("bus ack", {31'h0, ack}, 32'h1);
  endtask
  task automatic fire(input logic [13:0] m, input logic [7:0] iv, input logic [3:0] ei,
                      input logic [7:0] ev, input logic [31:0] pc, input logic cp);
    @(posedge clk);
    trp <= m; ivec <= iv; eidx <= ei;
    @(posedge clk);
    trp <= 14'h0000;
    #1;
    chk("take", {31'h0, take}, 32'h1);
    chk("vector", {24'h0, vec}, {24'h0, ev});
    chk("resume pc", spc, pc);
    chk("capture", {31'h0, cap}, {31'h0, cp});
    chk("vector address", va, {VB[31:10], ev, 2'b00});
  endtask
  task automatic await(input logic [7:0] ev);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (take !== 1'b1 && n < 20);
    chk("async vector", {24'h0, vec}, {24'h0, ev});
    chk("async pc", spc, NPC);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    wb(1'b0, 4'h0, 32'h0); chk("base reset", q, 32'h0);
    wb(1'b1, 4'h0, 32'hFFFFFFFF); wb(1'b0, 4'h0, 32'h0); chk("base", q, VB);
    wb(1'b0, 4'h1, 32'h0); chk("unmapped", q, 32'h0);
  endtask
  task automatic t_levels;
    for (int b = 0; b < 14; b++) begin
      if (b < 6 || b > 8) fire(14'h1 << b, 8'h00, 4'h0, VT[b], b < 9 ? NPC : CPC, b < 5);
    end
    fire(14'h0A09, 8'h00, 4'h0, 8'h09, NPC, 1'b1);
    fire(14'h0040, 8'h40, 4'h0, 8'h40, NPC, 1'b0);
    fire(14'h0080, 8'hFF, 4'h0, 8'hFF, NPC, 1'b0);
    for (int i = 0; i < 16; i++) fire(14'h0100, 8'h00, i, i > 10 ? 8'h3F : 8'h35 + i, NPC, 1'b0);
  endtask
  task automatic t_core_reset;
    @(posedge clk);
    trp <= 14'h0001; crst <= 1'b1;
    @(posedge clk);
    trp <= 14'h0000; crst <= 1'b0;
    #1;
    chk("take in reset", {31'h0, take}, 32'h0);
  endtask
  task automatic t_async;
    @(posedge clk); rse <= 3'h7;
    @(posedge clk); rse <= 3'h0;
    repeat (6) @(posedge clk);
    ok <= 1'b1;
    await(8'h10); await(8'h12); await(8'h13);
    @(posedge clk); ok <= 1'b0; rse <= 3'h2;
    @(posedge clk); rse <= 3'h0;
    repeat (5) @(posedge clk);
    wdr <= 3'h2;
    @(posedge clk); wdr <= 3'h0;
    repeat (4) @(posedge clk);
    ok <= 1'b1;
    await(8'h00);
    @(posedge clk); ok <= 1'b0;
  endtask
  task automatic t_flags;
    @(posedge clk); tmr <= 1'b1; trc <= 1'b1;
    @(posedge clk); tmr <= 1'b0; trc <= 1'b0;
    wb(1'b0, 4'h4, 32'h0); chk("both pending", q & 32'h3, 32'h3);
    wb(1'b1, 4'h8, 32'h1); wb(1'b0, 4'h4, 32'h0); chk("timer cleared", q & 32'h3, 32'h2);
    @(posedge clk); ok <= 1'b1;
    await(8'h0F);
    @(posedge clk); bkp <= 1'b1;
    @(posedge clk); bkp <= 1'b0;
    await(8'h0F);
    @(posedge clk); tmr <= 1'b1;
    @(posedge clk); tmr <= 1'b0;
    await(8'h0E);
    @(posedge clk); ok <= 1'b0;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial forever #12.5 clk = ~clk;
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_regs(); t_levels(); t_core_reset(); t_async(); t_flags();
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire
